// [hdl/rst_src_ctrl.sv]
// Reset source controller: merges hardware and software reset requests,
// drives core and peripheral resets, records the source of each reset.
// Assumes resetn is the power-on reset and request inputs are levels.
`timescale 1ns/1ps
module rst_src_ctrl
  import rst_src_pkg::*;
#(
  parameter int PULSE_CYC = `RST_PULSE_CYC
) (
  // Clock and power-on reset
  input  wire logic           clk_sys,
  input  wire logic           resetn,
  // Hardware reset requests (asynchronous)
  input  wire logic           external_reset_pin_n,
  input  wire logic           watchdog_timer_req,
  input  wire logic           window_watchdog_req,
  input  wire logic           low_voltage_reset_req,
  input  wire logic           brownout_detector_req,
  // Core lockup (same domain)
  input  wire logic           core_lockup,
  // Software control writes (same domain, one-cycle strobes)
  input  wire logic           prc0_wr,
  input  wire logic [2:0]     prc0_wdata,
  input  wire logic           circ_wr,
  input  wire logic [2:0]     circ_wdata,
  input  wire logic           status_clr_wr,
  input  wire logic [8:0]     status_clr_data,
  // Boot source select
  input  wire logic           boot_sel_in,
  // Outputs
  output logic                core_reset_n,
  output logic                periph_reset_n,
  output logic [8:0]          reset_source_status,
  output logic [1:0]          peripheral_reset_control_0,
  output logic                boot_sel
);

  // ------------------------------------------------------------
  // Synchronise pin-side requests
  // ------------------------------------------------------------
  logic [4:0] hw_raw;
  logic [4:0] hw_s;

  assign hw_raw = {brownout_detector_req, low_voltage_reset_req, window_watchdog_req,
                   watchdog_timer_req, ~external_reset_pin_n};

  sync2 #(.W(5), .INIT(5'h00)) u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .din     (hw_raw),
    .dout    (hw_s)
  );

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    rst_state_e st;
    src_vec_t   flags;
    logic [1:0] prc0;
    logic       core_n;
    logic       periph_n;
    logic       boot;
    logic       boot_init;
  } state_s;

  state_s s_q;
  state_s s_d;

  // Software pulses
  logic sw_chip;
  logic sw_mcu;
  logic sw_cpu;
  logic sys_start;
  logic core_start;
  logic sys_busy;
  logic core_busy;
  logic hw_any;
  src_vec_t ev;

  assign sw_chip = prc0_wr & prc0_wdata[`PRC0_CHIP_BIT];
  assign sw_cpu  = prc0_wr & prc0_wdata[`PRC0_CORE_BIT];
  assign sw_mcu  = circ_wr & circ_wdata[`CIRC_SYSREQ_BIT];
  assign hw_any  = |hw_s | core_lockup;

  always_comb begin
    ev = '0;
    ev[`RSS_PIN]    = hw_s[0];
    ev[`RSS_WDT]    = hw_s[1];
    ev[`RSS_WINDOW_WATCHDOG]   = hw_s[2];
    ev[`RSS_LVR]    = hw_s[3];
    ev[`RSS_BOD]    = hw_s[4];
    ev[`RSS_LOCKUP] = core_lockup;
    ev[`RSS_POR]    = sw_chip;
    ev[`RSS_MCU]    = sw_mcu;
    ev[`RSS_CPU]    = sw_cpu;
  end

  assign sys_start  = hw_any | sw_chip | sw_mcu;
  assign core_start = sw_cpu;

  rst_pulse_gen #(.LEN(PULSE_CYC)) u_sys_pulse (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .start   (sys_start),
    .busy    (sys_busy)
  );

  rst_pulse_gen #(.LEN(PULSE_CYC)) u_core_pulse (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .start   (core_start),
    .busy    (core_busy)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Set wins over clear; flags survive every reset but power-on
    s_d.flags = (s_q.flags & ~(status_clr_wr ? status_clr_data : 9'h000)) | ev;
    // Control bits self-clear after one cycle
    s_d.prc0 = {sw_cpu, sw_chip};
    s_d.boot_init = 1'b1;
    if (!s_q.boot_init) begin
      s_d.boot = boot_sel_in;
    end else if (sw_chip) begin
      s_d.boot = boot_sel_in;
    end
    unique case (s_q.st)
      ST_RUN: begin
        if (sys_start) begin
          s_d.st = ST_SYS;
        end else if (core_start) begin
          s_d.st = ST_CORE;
        end
      end
      ST_SYS: begin
        if (!sys_busy && !sys_start) begin
          s_d.st = ST_RUN;
        end
      end
      ST_CORE: begin
        if (sys_start) begin
          s_d.st = ST_SYS;
        end else if (!core_busy && !core_start) begin
          s_d.st = ST_RUN;
        end
      end
      default: s_d.st = ST_RUN;
    endcase
    s_d.core_n   = (s_d.st == ST_RUN);
    s_d.periph_n = (s_d.st != ST_SYS);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q.st        <= ST_RUN;
      s_q.flags     <= `RSS_RESET_VAL;
      s_q.prc0      <= 2'b00;
      s_q.core_n    <= 1'b0;
      s_q.periph_n  <= 1'b0;
      s_q.boot      <= 1'b0;
      s_q.boot_init <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign core_reset_n               = s_q.core_n;
  assign periph_reset_n             = s_q.periph_n;
  assign reset_source_status        = s_q.flags;
  assign peripheral_reset_control_0 = s_q.prc0;
  assign boot_sel                   = s_q.boot;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_pin_flag;
    @(posedge clk_sys) disable iff (!resetn) hw_s[0] |=> reset_source_status[`RSS_PIN];
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin flag not set");

  property p_wdt_rst;
    @(posedge clk_sys) disable iff (!resetn)
      (hw_s[1] || hw_s[2]) |=> !core_reset_n && !periph_reset_n;
  endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset missing");

  property p_lvr_rst;
    @(posedge clk_sys) disable iff (!resetn)
      hw_s[3] |=> !periph_reset_n && reset_source_status[`RSS_LVR];
  endproperty
  a_lvr_rst: assert property (p_lvr_rst) else $error("low voltage reset missing");

  property p_bod_rst;
    @(posedge clk_sys) disable iff (!resetn)
      hw_s[4] |=> !periph_reset_n && reset_source_status[`RSS_BOD];
  endproperty
  a_bod_rst: assert property (p_bod_rst) else $error("brown-out reset missing");

  property p_lock_rst;
    @(posedge clk_sys) disable iff (!resetn)
      core_lockup |=> !core_reset_n && reset_source_status[`RSS_LOCKUP];
  endproperty
  a_lock_rst: assert property (p_lock_rst) else $error("lockup reset missing");

  property p_core_only;
    @(posedge clk_sys) disable iff (!resetn)
      (sw_cpu && !sys_start && s_q.st == ST_RUN) |=> !core_reset_n && periph_reset_n;
  endproperty
  a_core_only: assert property (p_core_only) else $error("core-only reset wrong");

  property p_chip_rst;
    @(posedge clk_sys) disable iff (!resetn)
      sw_chip |=> !periph_reset_n && reset_source_status[`RSS_POR];
  endproperty
  a_chip_rst: assert property (p_chip_rst) else $error("chip reset missing");

  property p_mcu_rst;
    @(posedge clk_sys) disable iff (!resetn)
      sw_mcu |=> !periph_reset_n && reset_source_status[`RSS_MCU] && $stable(boot_sel);
  endproperty
  a_mcu_rst: assert property (p_mcu_rst) else $error("reboot reset wrong");

  property p_flag_hold;
    @(posedge clk_sys) disable iff (!resetn)
      (reset_source_status[`RSS_WDT] && !(status_clr_wr && status_clr_data[`RSS_WDT]))
        |=> reset_source_status[`RSS_WDT];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

  property p_self_clear;
    @(posedge clk_sys) disable iff (!resetn)
      (sw_chip ##1 !sw_chip) |=> !peripheral_reset_control_0[`PRC0_CHIP_BIT];
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("control bit stuck");

  property p_end;
    @(posedge clk_sys) disable iff (!resetn)
      (s_q.st == ST_SYS && !sys_busy && !sys_start) |=> periph_reset_n && core_reset_n;
  endproperty
  a_end: assert property (p_end) else $error("reset did not end");

  // ------------------------------------------------------------
  // Further source checks
  // ------------------------------------------------------------
  property p_pin_rst;
    @(posedge clk_sys) disable iff (!resetn)
      hw_s[0] |=> !core_reset_n && !periph_reset_n;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset missing");

  property p_wdt_flag;
    @(posedge clk_sys) disable iff (!resetn)
      hw_s[1] |=> reset_source_status[`RSS_WDT];
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag missing");

  property p_window_watchdog_flag;
    @(posedge clk_sys) disable iff (!resetn)
      hw_s[2] |=> reset_source_status[`RSS_WINDOW_WATCHDOG];
  endproperty
  a_window_watchdog_flag: assert property (p_window_watchdog_flag) else $error("window flag missing");

  property p_core_flag;
    @(posedge clk_sys) disable iff (!resetn)
      sw_cpu |=> !core_reset_n && reset_source_status[`RSS_CPU];
  endproperty
  a_core_flag: assert property (p_core_flag) else $error("core reset flag missing");

  property p_chip_read;
    @(posedge clk_sys) disable iff (!resetn)
      sw_chip |=> peripheral_reset_control_0[`PRC0_CHIP_BIT];
  endproperty
  a_chip_read: assert property (p_chip_read) else $error("chip bit readback");

  property p_core_read;
    @(posedge clk_sys) disable iff (!resetn)
      sw_cpu |=> peripheral_reset_control_0[`PRC0_CORE_BIT];
  endproperty
  a_core_read: assert property (p_core_read) else $error("core bit readback");

  property p_periph_core;
    @(posedge clk_sys) disable iff (!resetn)
      !periph_reset_n |-> !core_reset_n;
  endproperty
  a_periph_core: assert property (p_periph_core) else $error("core runs in reset");

  property p_sys_start;
    @(posedge clk_sys) disable iff (!resetn)
      sys_start |=> !periph_reset_n && !core_reset_n;
  endproperty
  a_sys_start: assert property (p_sys_start) else $error("system reset missing");

endmodule // rst_src_ctrl

// [hdl/rst_src_map.svh]
// Constants of the reset source controller: status bit positions, control bits, timing.
// Assumes inclusion by the package and the design modules of this block.
`ifndef RST_SRC_MAP_SVH
`define RST_SRC_MAP_SVH

`define RSS_WIDTH        9
`define RSS_POR          0
`define RSS_PIN          1
`define RSS_WDT          2
`define RSS_LVR          3
`define RSS_BOD          4
`define RSS_MCU          5
`define RSS_WINDOW_WATCHDOG         6
`define RSS_CPU          7
`define RSS_LOCKUP       8
`define RSS_RESET_VAL    9'h001

`define PRC0_CHIP_BIT    0
`define PRC0_CORE_BIT    1
`define CIRC_SYSREQ_BIT  2

`define RST_PULSE_NS     64
`define CLK_PERIOD_NS    4
`define RST_PULSE_CYC    ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [hdl/rst_src_pkg.sv]
// Types of the reset source controller.
// Assumes rst_src_map.svh is on the include path.
`include "rst_src_map.svh"
package rst_src_pkg;
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_SYS  = 2'b01,
    ST_CORE = 2'b10
  } rst_state_e;

  typedef logic [`RSS_WIDTH-1:0] src_vec_t;
endpackage

// [hdl/sync2.sv]
// Two flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes the inputs are quasi-static relative to clk_sys.
`timescale 1ns/1ps
module sync2 #(
  parameter int          W       = 1,
  parameter logic [W-1:0] INIT   = '0
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q <= INIT;
      dout   <= INIT;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // sync2

// [hdl/rst_pulse_gen.sv]
// Fixed-length pulse stretcher: a start gives LEN cycles of active output.
// Assumes start is a same-domain pulse or level.
`timescale 1ns/1ps
module rst_pulse_gen #(
  parameter int LEN = 16
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Control
  input  wire logic start,
  output logic      busy
);
  localparam int CW = $clog2(LEN + 1);
  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      busy  <= 1'b0;
    end else if (start) begin
      cnt_q <= CW'(LEN - 1);
      busy  <= 1'b1;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end else begin
      busy  <= 1'b0;
    end
  end
endmodule // rst_pulse_gen

// [tb/rst_src_partner.sv]
// Model of the reset sources around the controller: pin, watchdogs, detectors, core.
// Assumes the bench pulses go for one cycle with sel naming the source.
`timescale 1ns/1ps
module rst_src_partner (
  // Clock and core reset seen by the core
  input  wire logic       clk_sys,
  input  wire logic       core_reset_n,
  // Bench command
  input  wire logic       go,
  input  wire logic [2:0] sel,
  // Request levels
  output logic            pin_n,
  output logic            wdt,
  output logic            window_watchdog,
  output logic            low_voltage_reset,
  output logic            brownout_detector,
  output logic            lockup
);
  int         cnt;
  logic [2:0] cur;
  logic       g;
  logic [2:0] s;

  initial begin
    cnt = 0; cur = 3'h0;
    pin_n = 1'b1; wdt = 1'b0; window_watchdog = 1'b0; low_voltage_reset = 1'b0; brownout_detector = 1'b0; lockup = 1'b0;
  end

  // ----------------------------------------
  // Hold the chosen pin, watchdog or detector request four cycles
  // ----------------------------------------
  always @(posedge clk_sys) begin
    g = go;
    s = sel;
    #1;
    if (g) begin
      cur = s;
      cnt = 4;
    end else if (cnt != 0) begin
      cnt = cnt - 1;
    end
    pin_n = !(cnt != 0 && cur == 3'h0);
    wdt   = (cnt != 0 && cur == 3'h1);
    window_watchdog  = (cnt != 0 && cur == 3'h2);
    low_voltage_reset   = (cnt != 0 && cur == 3'h3);
    brownout_detector   = (cnt != 0 && cur == 3'h4);
    // Core stays locked up until its reset arrives
    if (g && s == 3'h5) begin
      lockup = 1'b1;
    end else if (!core_reset_n) begin
      lockup = 1'b0;
    end
  end
endmodule // rst_src_partner

// [tb/tb_rst_src_ctrl.sv]
// Self-checking bench of the reset source controller.
// Assumes the partner model drives the hardware requests.
`timescale 1ns/1ps
`include "rst_src_map.svh"
module tb_rst_src_ctrl;
  import rst_src_pkg::*;
  logic       clk_sys = 1'b0, resetn = 1'b0, prc0_wr = 1'b0, circ_wr = 1'b0;
  logic [2:0] prc0_wdata = 3'h0, circ_wdata = 3'h0, sel = 3'h0;
  logic       status_clr_wr = 1'b0, boot_sel_in = 1'b1, go = 1'b0;
  logic [8:0] status_clr_data = 9'h000;
  logic       pin_n, wdt, window_watchdog, low_voltage_reset, brownout_detector, lockup, core_reset_n, periph_reset_n, boot_sel;
  logic [8:0] reset_source_status, exp;
  logic [1:0] peripheral_reset_control_0;
  int         errors = 0, check_count = 0, bitpos[6];
  bit         periph_low;

  always #2 clk_sys = ~clk_sys;

  rst_src_ctrl #(.PULSE_CYC(2)) rst_src_ctrl_inst (
    .clk_sys(clk_sys), .resetn(resetn), .external_reset_pin_n(pin_n),
    .watchdog_timer_req(wdt), .window_watchdog_req(window_watchdog), .low_voltage_reset_req(low_voltage_reset),
    .brownout_detector_req(brownout_detector), .core_lockup(lockup), .prc0_wr(prc0_wr),
    .prc0_wdata(prc0_wdata), .circ_wr(circ_wr), .circ_wdata(circ_wdata),
    .status_clr_wr(status_clr_wr), .status_clr_data(status_clr_data),
    .boot_sel_in(boot_sel_in), .core_reset_n(core_reset_n), .periph_reset_n(periph_reset_n),
    .reset_source_status(reset_source_status),
    .peripheral_reset_control_0(peripheral_reset_control_0), .boot_sel(boot_sel));

  rst_src_partner rst_src_partner_inst (
    .clk_sys(clk_sys), .core_reset_n(core_reset_n), .go(go), .sel(sel), .pin_n(pin_n),
    .wdt(wdt), .window_watchdog(window_watchdog), .low_voltage_reset(low_voltage_reset), .brownout_detector(brownout_detector), .lockup(lockup));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [8:0] seen, input logic [8:0] want, input string what);
    check_count++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic sw_write(input bit core_ctl, input logic [2:0] d);
    @(posedge clk_sys); #1;
    if (core_ctl) begin circ_wr = 1'b1; circ_wdata = d; end
    else begin prc0_wr = 1'b1; prc0_wdata = d; end
    @(posedge clk_sys); #1;
    circ_wr = 1'b0;
    prc0_wr = 1'b0;
  endtask

  task automatic clear(input logic [8:0] m);
    @(posedge clk_sys); #1;
    status_clr_wr = 1'b1;
    status_clr_data = m;
    @(posedge clk_sys); #1;
    status_clr_wr = 1'b0;
    @(posedge clk_sys); #1;
  endtask

  task automatic fire(input logic [2:0] s);
    @(posedge clk_sys); #1;
    go = 1'b1;
    sel = s;
    @(posedge clk_sys); #1;
    go = 1'b0;
  endtask

  task automatic wait_core(input logic lvl);
    int n;
    n = 0;
    while (core_reset_n !== lvl) begin
      @(posedge clk_sys); #1;
      if (periph_reset_n !== 1'b1) periph_low = 1'b1;
      n++;
      if (n > 60) begin
        errors++;
        $display("MISMATCH %0t wait on core reset timed out", $time);
        close_out();
      end
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    bitpos = '{`RSS_PIN, `RSS_WDT, `RSS_WINDOW_WATCHDOG, `RSS_LVR, `RSS_BOD, `RSS_LOCKUP};
    repeat (20) @(posedge clk_sys);
    #1 resetn = 1'b1;
    @(posedge clk_sys); #1;
    check(reset_source_status, `RSS_RESET_VAL, "status after power-on");
    check(core_reset_n & periph_reset_n, 1'b1, "resets released");
    check(boot_sel, 1'b1, "boot source captured");
    clear(9'h1ff);
    check(reset_source_status, 9'h000, "status cleared");
    $display("test power-on done");

    exp = 9'h000;
    for (int i = 0; i < 6; i++) begin
      fire(i[2:0]);
      wait_core(1'b0);
      check(periph_reset_n, 1'b0, "peripherals in reset");
      wait_core(1'b1);
      @(posedge clk_sys); #1;
      check(periph_reset_n, 1'b1, "peripherals released");
      exp = exp | (9'h001 << bitpos[i]);
      check(reset_source_status, exp, "flags after source");
    end
    clear(9'h001 << `RSS_WDT);
    exp = exp & ~(9'h001 << `RSS_WDT);
    check(reset_source_status, exp, "single flag cleared");
    clear(9'h1ff);
    $display("test hardware sources done");

    boot_sel_in = 1'b0;
    sw_write(1'b1, 3'h4);
    wait_core(1'b0);
    check(periph_reset_n, 1'b0, "reboot resets peripherals");
    wait_core(1'b1);
    @(posedge clk_sys); #1;
    check(reset_source_status, 9'h001 << `RSS_MCU, "reboot flag");
    check(boot_sel, 1'b1, "boot source kept");
    clear(9'h1ff);

    sw_write(1'b0, 3'h1);
    check(peripheral_reset_control_0, 2'b01, "chip bit readback");
    check(periph_reset_n | core_reset_n, 1'b0, "chip reset applied");
    @(posedge clk_sys); #1;
    check(peripheral_reset_control_0, 2'b00, "chip bit self-clears");
    wait_core(1'b1);
    @(posedge clk_sys); #1;
    check(reset_source_status, 9'h001 << `RSS_POR, "chip flag");
    check(boot_sel, 1'b0, "boot source recaptured");
    clear(9'h1ff);

    periph_low = 1'b0;
    sw_write(1'b0, 3'h2);
    check(peripheral_reset_control_0, 2'b10, "core bit readback");
    if (periph_reset_n !== 1'b1) periph_low = 1'b1;
    wait_core(1'b0);
    wait_core(1'b1);
    @(posedge clk_sys); #1;
    check(periph_low, 1'b0, "peripherals kept running");
    check(reset_source_status, 9'h001 << `RSS_CPU, "core-only flag");
    check(peripheral_reset_control_0, 2'b00, "core bit self-clears");
    $display("test software sources done");
    close_out();
  end
endmodule // tb_rst_src_ctrl
